// File: logic/ext_irq_pkg.sv
package ext_irq_pkg;

    localparam int NUM_LINES = 4;

    // register byte offsets on the bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] REQ_OFS  = 8'h0c;
    localparam int         OFS_W    = 8;

    // control register layout
    localparam int         G2_SEL_LSB = 6;
    localparam int         G2_POL_BIT = 5;
    localparam int         G1_SEL_LSB = 3;
    localparam int         G1_POL_BIT = 2;
    localparam int         SEL_W      = 2;
    localparam int         CTRL_W     = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hfc;
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // line positions in status, mask and request vectors
    localparam int LINE_ZERO  = 0;
    localparam int LINE_ONE   = 1;
    localparam int LINE_TWO   = 2;
    localparam int LINE_THREE = 3;

    localparam logic [1:0] SEL_EDGE_LEVEL = 2'b00;
    localparam logic [1:0] SEL_RISE       = 2'b01;
    localparam logic [1:0] SEL_FALL       = 2'b10;
    localparam logic [1:0] SEL_BOTH       = 2'b11;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [2:0] {
        SENSE_FALL_LOW,
        SENSE_RISE_HIGH,
        SENSE_RISE,
        SENSE_FALL,
        SENSE_BOTH
    } sense_t;

    // inversion swaps the sense of every mode except both edges
    function automatic sense_t decode_sense(input logic [1:0] sel, input logic inv);
        sense_t s;
        s = SENSE_BOTH;
        unique case (sel)
            SEL_EDGE_LEVEL: s = inv ? SENSE_RISE_HIGH : SENSE_FALL_LOW;
            SEL_RISE:       s = inv ? SENSE_FALL : SENSE_RISE;
            SEL_FALL:       s = inv ? SENSE_RISE : SENSE_FALL;
            SEL_BOTH:       s = SENSE_BOTH;
        endcase
        return s;
    endfunction : decode_sense

endpackage : ext_irq_pkg

// File: logic/edge_sense.sv
`timescale 1ns/100ps
`default_nettype none
module edge_sense
    import ext_irq_pkg::*;
#(
    parameter int PINS = 4
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic [PINS-1:0] pins,
    input  wire sense_t          sense,
    input  wire logic            clear,
    input  wire logic            ack,
    output logic                 req,
    output logic                 event_p
);
    logic valid_q;
    logic low_q;
    logic high_q;
    logic pend_q;
    logic lvl_q;

    // any pin low pulls the line low, any pin high drives it high
    wire agg_low   = &pins;
    wire agg_high  = |pins;
    wire fell      = valid_q & low_q & ~agg_low;
    wire rose      = valid_q & ~high_q & agg_high;
    wire edge_hit  = ((sense == SENSE_FALL_LOW || sense == SENSE_FALL) & fell)
                   | ((sense == SENSE_RISE_HIGH || sense == SENSE_RISE) & rose)
                   | ((sense == SENSE_BOTH) & (fell | rose));
    wire level_hit = ((sense == SENSE_FALL_LOW) & ~agg_low)
                   | ((sense == SENSE_RISE_HIGH) & agg_high);

    assign req     = pend_q | level_hit;
    assign event_p = edge_hit | (level_hit & ~lvl_q);

    // first cycle after reset only primes the history, no edge is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid_q <= 1'b0;
            low_q   <= 1'b1;
            high_q  <= 1'b0;
            pend_q  <= 1'b0;
            lvl_q   <= 1'b0;
        end else begin
            valid_q <= 1'b1;
            low_q   <= agg_low;
            high_q  <= agg_high;
            lvl_q   <= level_hit;
            // a new edge wins over a clear in the same cycle
            pend_q  <= edge_hit | (pend_q & ~clear & ~ack);
        end
    end
endmodule : edge_sense
`default_nettype wire

// File: logic/ahb_reg_slave.sv
`timescale 1ns/100ps
`default_nettype none
module ahb_reg_slave
    import ext_irq_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic             hready,
    input  wire logic [31:0]      rd_data,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    output logic                  wr_en,
    output logic [OFS_W-1:0]      wr_ofs,
    output logic                  rd_en,
    output logic [OFS_W-1:0]      rd_ofs
);
    logic             wr_pend_q;
    logic [OFS_W-1:0] wr_ofs_q;
    logic [31:0]      hrdata_q;

    wire active = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    // zero wait states: reads are sampled at the address phase edge
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_q;
    assign rd_en     = active & ~hwrite;
    assign rd_ofs    = haddr[OFS_W-1:0];
    assign wr_en     = wr_pend_q;
    assign wr_ofs    = wr_ofs_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_ofs_q  <= '0;
            hrdata_q  <= '0;
        end else begin
            if (hready) begin
                wr_pend_q <= active & hwrite;
                wr_ofs_q  <= haddr[OFS_W-1:0];
            end
            if (rd_en) begin
                hrdata_q <= rd_data;
            end
        end
    end
endmodule : ahb_reg_slave
`default_nettype wire

// File: logic/ext_irq_sensitivity_ctrl.sv
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_sensitivity_ctrl
    import ext_irq_pkg::*;
#(
    parameter int A_PINS = 4,
    parameter int F_PINS = 3,
    parameter int B_PINS = 5
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic [A_PINS-1:0]    port_a_in,
    input  wire logic [F_PINS-1:0]    port_f_in,
    input  wire logic [B_PINS-1:0]    port_b_in,
    input  wire logic [NUM_LINES-1:0] irq_ack,
    output logic [NUM_LINES-1:0]      irq_req,
    output logic                      irq
);
    logic [CTRL_W-1:0]    ctrl_q;
    logic [NUM_LINES-1:0] stat_q;
    logic [NUM_LINES-1:0] mask_q;
    logic [NUM_LINES-1:0] line_event;
    logic                 wr_en;
    logic [OFS_W-1:0]     wr_ofs;
    logic                 rd_en;
    logic [OFS_W-1:0]     rd_ofs;
    logic [31:0]          rd_data;

    ahb_reg_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .rd_data   (rd_data),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr_en     (wr_en),
        .wr_ofs    (wr_ofs),
        .rd_en     (rd_en),
        .rd_ofs    (rd_ofs)
    );

    // only whole-word transfers are issued, so size is not decoded
    wire unused_size = ^hsize;

    wire wr_ctrl = wr_en & (wr_ofs == CTRL_OFS);
    wire wr_mask = wr_en & (wr_ofs == MASK_OFS);
    wire rd_stat = rd_en & (rd_ofs == STAT_OFS);

    wire [CTRL_W-1:0] ctrl_new = hwdata[CTRL_W-1:0] & CTRL_WMASK;

    wire [SEL_W-1:0] g2_sel = ctrl_q[G2_SEL_LSB +: SEL_W];
    wire             g2_pol = ctrl_q[G2_POL_BIT];
    wire [SEL_W-1:0] g1_sel = ctrl_q[G1_SEL_LSB +: SEL_W];
    wire             g1_pol = ctrl_q[G1_POL_BIT];

    // a write of the same value keeps pending requests intact
    wire g2_change = wr_ctrl & ((ctrl_new[G2_SEL_LSB +: SEL_W] != g2_sel)
                              | (ctrl_new[G2_POL_BIT] != g2_pol));
    wire g1_change = wr_ctrl & ((ctrl_new[G1_SEL_LSB +: SEL_W] != g1_sel)
                              | (ctrl_new[G1_POL_BIT] != g1_pol));

    wire sense_t sense_zero  = decode_sense(g1_sel, g1_pol);
    wire sense_t sense_one   = decode_sense(g1_sel, 1'b0);
    wire sense_t sense_two   = decode_sense(g2_sel, g2_pol);
    wire sense_t sense_three = decode_sense(g2_sel, 1'b0);

    edge_sense #(.PINS(A_PINS)) u_line_zero (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pins    (port_a_in),
        .sense   (sense_zero),
        .clear   (g1_change),
        .ack     (irq_ack[LINE_ZERO]),
        .req     (irq_req[LINE_ZERO]),
        .event_p (line_event[LINE_ZERO])
    );

    edge_sense #(.PINS(F_PINS)) u_line_one (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pins    (port_f_in),
        .sense   (sense_one),
        .clear   (g1_change),
        .ack     (irq_ack[LINE_ONE]),
        .req     (irq_req[LINE_ONE]),
        .event_p (line_event[LINE_ONE])
    );

    // port B pins 3:0 feed line two, pin 4 feeds line three
    edge_sense #(.PINS(B_PINS-1)) u_line_two (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pins    (port_b_in[B_PINS-2:0]),
        .sense   (sense_two),
        .clear   (g2_change),
        .ack     (irq_ack[LINE_TWO]),
        .req     (irq_req[LINE_TWO]),
        .event_p (line_event[LINE_TWO])
    );

    edge_sense #(.PINS(1)) u_line_three (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pins    (port_b_in[B_PINS-1]),
        .sense   (sense_three),
        .clear   (g2_change),
        .ack     (irq_ack[LINE_THREE]),
        .req     (irq_req[LINE_THREE]),
        .event_p (line_event[LINE_THREE])
    );

    // read-back mux; unmapped offsets read zero
    always_comb begin
        rd_data = '0;
        unique case (rd_ofs)
            CTRL_OFS: rd_data[CTRL_W-1:0]    = ctrl_q;
            STAT_OFS: rd_data[NUM_LINES-1:0] = stat_q;
            MASK_OFS: rd_data[NUM_LINES-1:0] = mask_q;
            REQ_OFS:  rd_data[NUM_LINES-1:0] = irq_req;
            default:  rd_data = '0;
        endcase
    end

    // status is cleared by reading it; an event in that cycle survives
    wire [NUM_LINES-1:0] stat_d = (stat_q & ~{NUM_LINES{rd_stat}}) | line_event;

    assign irq = |(stat_q & mask_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
            stat_q <= STAT_RESET;
            mask_q <= MASK_RESET;
        end else begin
            stat_q <= stat_d;
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new;
            end
            if (wr_mask) begin
                mask_q <= hwdata[NUM_LINES-1:0];
            end
        end
    end
endmodule : ext_irq_sensitivity_ctrl
`default_nettype wire

// File: test/irq_sens_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none
module irq_sens_checker
    import ext_irq_pkg::*;
#(
    parameter int A_PINS = 4,
    parameter int B_PINS = 5
) (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic [31:0]          hrdata,
    input wire logic [A_PINS-1:0]    port_a_in,
    input wire logic [B_PINS-1:0]    port_b_in,
    input wire logic [NUM_LINES-1:0] irq_ack,
    input wire logic [NUM_LINES-1:0] irq_req
);
    logic       wp_q;
    logic [7:0] ctl_q;
    wire logic       ctl_ap = hsel && hready && htrans[1] && haddr[7:0] == CTRL_OFS;
    wire logic [1:0] g2     = ctl_q[7:6];
    // shadow of the control register rebuilt from bus traffic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q  <= 1'b0;
            ctl_q <= CTRL_RESET;
        end else begin
            wp_q  <= ctl_ap && hwrite;
            ctl_q <= wp_q ? (hwdata[7:0] & CTRL_WMASK) : ctl_q;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a write landing on the same edge may switch the sense, so skip it
    sequence b4_fell;
        !wp_q && $fell(port_b_in[4]);
    endsequence
    sequence b4_rose;
        !wp_q && $rose(port_b_in[4]);
    endsequence
    three_fall_a: assert property (g2 == SEL_FALL ##0 b4_fell |=> irq_req[3])
        else $error("line three missed a falling edge");
    three_rise_a: assert property (g2 == SEL_RISE ##0 b4_rose |=> irq_req[3])
        else $error("line three missed a rising edge");
    three_level_a: assert property (g2 == SEL_EDGE_LEVEL && !port_b_in[4] |-> irq_req[3])
        else $error("line three low level not requesting");
    ack_clear_a: assert property (g2 != SEL_EDGE_LEVEL && !wp_q
        && irq_req[3] && irq_ack[3] && $stable(port_b_in[4]) |=> !irq_req[3])
        else $error("acknowledge did not clear line three");
    two_inv_a: assert property (g2 == SEL_FALL && ctl_q[5] && !wp_q && $rose(|port_b_in[3:0])
        |=> irq_req[2]) else $error("inverted falling mode missed rising edge");
    zero_high_a: assert property (ctl_q[4:0] == 5'h04 && |port_a_in |-> irq_req[0])
        else $error("line zero high level not requesting");
    ctrl_read_a: assert property (ctl_ap && !hwrite
        |=> hrdata == {24'h00_0000, $past(ctl_q)}) else $error("control read data wrong");
    sel_change_a: assert property (wp_q && hwdata[7:5] != ctl_q[7:5]
        && hwdata[7:6] != 2'b00 && $stable(port_b_in[4]) |=> !irq_req[3])
        else $error("pending kept after sense change");
endmodule : irq_sens_checker
`default_nettype wire

// File: test/ext_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module ext_pin_model (
    input  wire logic       hclk,
    output logic      [3:0] port_a,
    output logic      [2:0] port_f,
    output logic      [4:0] port_b
);
    // pins rest high so the reset mode, falling plus low, raises nothing
    initial begin
        port_a = 4'hf;
        port_f = 3'h7;
        port_b = 5'h1f;
    end
    // all pins of a line move together
    task automatic set_line(input int line, input logic lvl);
        @(posedge hclk);
        case (line)
            0: port_a <= {4{lvl}};
            1: port_f <= {3{lvl}};
            2: port_b[3:0] <= {4{lvl}};
            default: port_b[4] <= lvl;
        endcase
    endtask : set_line
endmodule : ext_pin_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import ext_irq_pkg::*;
;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b1;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'b00;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic [3:0]  irq_ack = 4'h0;
    logic [31:0] rd;
    wire logic        hreadyout, hresp, irq;
    wire logic [31:0] hrdata;
    wire logic [3:0]  irq_req, port_a;
    wire logic [2:0]  port_f;
    wire logic [4:0]  port_b;
    int error_cnt = 0;
    int comparisons = 0;
    always #5 hclk = ~hclk;
    ext_irq_sensitivity_ctrl ext_irq_sensitivity_ctrl_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .port_a_in(port_a), .port_f_in(port_f), .port_b_in(port_b),
        .irq_ack(irq_ack), .irq_req(irq_req), .irq(irq));
    ext_pin_model ext_pin_model_i (.hclk(hclk), .port_a(port_a), .port_f(port_f), .port_b(port_b));
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            results();
        end
    endtask : wait_ready
    // control writes assume software holds interrupts off meanwhile
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'(hresp), 32'(HRESP_OKAY));
    endtask : xfer
    task automatic rd_chk(input logic [7:0] a, input string nm, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(nm, rd, e);
    endtask : rd_chk
    task automatic ack();
        @(posedge hclk);
        irq_ack <= 4'hf;
        @(posedge hclk);
        irq_ack <= 4'h0;
    endtask : ack
    task automatic settle();
        @(posedge hclk);
        @(negedge hclk);
    endtask : settle
    function automatic logic exp_req(input logic [1:0] sel, input logic inv, input logic low);
        case (sel)
            SEL_RISE: return !low ^ inv;
            SEL_BOTH: return 1'b1;
            default:  return low ^ inv;
        endcase
    endfunction : exp_req
    task automatic regs_scn();
        rd_chk(CTRL_OFS, "ctrl reset", {24'h00_0000, CTRL_RESET});
        rd_chk(REQ_OFS, "req idle", 32'h0);
        xfer(CTRL_OFS, 1'b1, 32'hffff_ffff);
        rd_chk(CTRL_OFS, "ctrl fields", 32'h0000_00fc);
        xfer(MASK_OFS, 1'b1, 32'hffff_ffff);
        rd_chk(MASK_OFS, "mask", 32'h0000_000f);
        rd_chk(8'h10, "unmapped", 32'h0);
        xfer(MASK_OFS, 1'b1, 32'h0);
    endtask : regs_scn
    task automatic sweep_scn();
        logic [7:0] c;
        logic       inv;
        for (int ln = 0; ln < 4; ln++) begin
            for (int m = 0; m < 8; m++) begin
                c = ln > 1 ? {m[2:0], 5'h00} : {3'b000, m[2:0], 2'b00};
                inv = m[0] && !ln[0];
                xfer(CTRL_OFS, 1'b1, {24'h00_0000, c});
                ack();
                ext_pin_model_i.set_line(ln, 1'b0);
                settle();
                chk("req low", 32'(irq_req[ln]),
                    32'(exp_req(m[2:1], inv, 1'b1)));
                ack();
                ext_pin_model_i.set_line(ln, 1'b1);
                settle();
                chk("req high", 32'(irq_req[ln]), 32'(exp_req(m[2:1], inv, 1'b0)));
                ack();
            end
        end
    endtask : sweep_scn
    task automatic irq_scn();
        xfer(STAT_OFS, 1'b0, 32'h0);
        xfer(CTRL_OFS, 1'b1, 32'h0000_0080);
        ext_pin_model_i.set_line(3, 1'b0);
        settle();
        chk("irq masked", 32'(irq), 32'h0);
        xfer(MASK_OFS, 1'b1, 32'h0000_0008);
        settle();
        chk("irq unmasked", 32'(irq), 32'h1);
        rd_chk(STAT_OFS, "status", 32'h0000_0008);
        settle();
        chk("irq after read", 32'(irq), 32'h0);
        rd_chk(STAT_OFS, "status cleared", 32'h0);
    endtask : irq_scn
    task automatic change_scn();
        logic [31:0] vals [3] = '{32'h0000_0080, 32'h0000_0084, 32'h0000_00a0};
        rd_chk(REQ_OFS, "req reg", 32'h0000_0008);
        for (int i = 0; i < 3; i++) begin
            xfer(CTRL_OFS, 1'b1, vals[i]);
            @(negedge hclk);
            chk("pending after write", 32'(irq_req[3]), 32'(i < 2));
        end
        ext_pin_model_i.set_line(3, 1'b1);
    endtask : change_scn
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        regs_scn();
        sweep_scn();
        irq_scn();
        change_scn();
        results();
    end
endmodule : tb_top
bind ext_irq_sensitivity_ctrl irq_sens_checker #(.A_PINS(A_PINS), .B_PINS(B_PINS)) chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .port_a_in(port_a_in), .port_b_in(port_b_in), .irq_ack(irq_ack), .irq_req(irq_req));
`default_nettype wire
